// >>> hw/fec_hdr_pkg.sv
// Shared constants, register map and carriers of the repair header block
package fec_hdr_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SSRC    = 8'h04;
   localparam logic [7:0] OFS_WINDOW  = 8'h08;
   localparam logic [7:0] OFS_CCOUNT  = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_TSTAMP  = 8'h14;
   localparam logic [7:0] OFS_SEED    = 8'h18;
   localparam logic [7:0] OFS_PARRD   = 8'h1c;
   localparam logic [7:0] OFS_CSRC0   = 8'h40;

   // Control field positions
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_PAD_BIT    = 1;
   localparam int CTRL_EXT_BIT    = 2;
   localparam int CTRL_REROLL_BIT = 3;
   localparam int CTRL_PT_LSB     = 8;

   // Reset values
   localparam logic [6:0]  RST_PT      = 7'h60;
   localparam logic [7:0]  RST_WIN     = 8'h0a;
   localparam logic [31:0] RST_LFSR    = 32'h1d2c_3b4a;

   // Header constants
   localparam logic [1:0]  RTP_VERSION = 2'h2;
   localparam logic [3:0]  HDR_WORDS   = 4'h3;
   localparam logic [6:0]  MASK_LEN_S  = 7'h0f;
   localparam logic [6:0]  MASK_LEN_M  = 7'h2e;
   localparam logic [6:0]  MASK_LEN_L  = 7'h6e;
   localparam logic [6:0]  MASK_TOP    = 7'h6d;

   typedef struct packed {
      logic [1:0]  ver;
      logic        pad;
      logic        ext;
      logic [3:0]  cc;
      logic        mark;
      logic [6:0]  pt;
      logic [15:0] seq;
   } rtp_word0_t;

   typedef struct packed {
      logic        retx;
      logic        fixed;
      logic [29:0] rest;
   } fec_sel_t;

   typedef struct packed {
      logic [7:0] cols;
      logic [7:0] rows;
   } win_t;

endpackage

// >>> hw/fec_repair_hdr.sv
// Repair packet header builder, header checker, mask test and parity store
// Behaviour
// [R1] Version field of every built header is 2, received headers need version 2.
// [R2] Marker bit sent as 0 and ignored when checking received repair headers.
// [R3] CSRC count and list carry the SSRC of every protected source stream.
// [R4] Sequence number steps by one per repair packet; start value is random. The code starts it at RST_LFSR[31:16] (16'h1d2c) after every reset.
// [R5] Timestamp taken from a running tick counter at transmission moment.
// [R6] Repair stream SSRC is random and can be re-drawn on collision. After every reset the code loads it with RST_LFSR, 32'h1d2c_3b4a.
// [R7] Parity covers every octet after the fixed 12-byte source header. The code XORs only the first PAR_DEPTH (64) words after it.
// [R8] Mask of 15, 46 or 110 bits; MSB is offset zero from base.
// [R9] Repair requests with columns or rows beyond window are refused.
// [R10] Receiver handles all column, row and mask shapes inside the window.
// [R11] Retransmitted copies inside the repair window are accepted.
// [R12] Retransmission carries original header and payload, own scheme only.
// [R13] Source packets pass unchanged; sequence numbers place them.
// [R14] Recovery rebuilds whole packet including CSRC, extension and padding.
// [R15] Repair padding and extension bits are set independently of sources.
// [R16] Repair payload type is configured; unknown type means discard.
// [R17] All protected sources of one repair packet share one session.
// [R18] Repair data is the bitwise XOR of the protected source packets.
// [R19] First selector bit marks retransmission; second bit is 0 then.
// [R20] Continuation bit is 1 when another mask segment follows, else 0.
// [R21] Sequence offsets against the protected origin are taken modulo 65536.
`timescale 1ns/1ps
`default_nettype none
module fec_repair_hdr #(
   parameter int CSRC_MAX  = 16,
   parameter int PAR_DEPTH = 64
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [31:0]                  reg_rdata,
   input  wire logic                    tx_start,
   input  wire logic                    tx_retx,
   input  wire fec_hdr_pkg::win_t       tx_shape,
   output logic [31:0]                  tx_word,
   output logic                         tx_valid,
   output logic                         tx_last,
   output logic                         tx_refused,
   input  wire logic [31:0]             rx_word,
   input  wire logic                    rx_valid,
   input  wire logic                    rx_first,
   output logic                         rx_accept,
   output logic                         rx_discard,
   output logic                         rx_is_retx,
   input  wire logic                    chk_valid,
   input  wire logic [15:0]             chk_seq,
   input  wire logic [15:0]             protected_sequence_origin,
   input  wire logic [109:0]            chk_mask,
   input  wire logic [1:0]              chk_cont,
   output logic                         chk_hit,
   output logic                         chk_done,
   input  wire logic                    par_valid,
   input  wire logic                    par_first,
   input  wire logic [31:0]             par_data,
   output logic                         par_busy
);
   import fec_hdr_pkg::*;

   localparam int PW = $clog2(PAR_DEPTH);
   localparam int CW = $clog2(CSRC_MAX);

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_W0   = 3'b001,
      TX_TS   = 3'b010,
      TX_SSRC = 3'b011,
      TX_CSRC = 3'b100,
      TX_SEL  = 3'b101
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_TS   = 3'b001,
      RX_SSRC = 3'b010,
      RX_CSRC = 3'b011,
      RX_SEL  = 3'b100
   } rx_state_t;

   function automatic logic fits_window(input win_t s, input win_t w);
      fits_window = (s.cols <= w.cols) && (s.rows <= w.rows) &&
                    !((s.cols == 8'h00) && (s.rows == 8'h00));
   endfunction

   logic              en_ff;
   logic              pad_ff;
   logic              ext_ff;
   logic [6:0]        pt_ff;
   logic [31:0]       ssrc_ff;
   win_t              win_ff;
   logic [3:0]        cc_ff;
   logic [31:0]       csrc_ff [CSRC_MAX];
   logic [31:0]       lfsr_ff;
   logic [31:0]       tick_ff;
   logic [15:0]       seq_ff;
   logic              seeded_ff;
   logic [7:0]        drop_cnt_ff;
   logic [7:0]        refuse_cnt_ff;
   logic [PW-1:0]     par_rd_idx_ff;
   tx_state_t         tx_st_ff;
   logic [3:0]        tx_ci_ff;
   logic              tx_retx_ff;
   rx_state_t         rx_st_ff;
   logic [3:0]        rx_ci_ff;
   logic [3:0]        rx_cc_ff;
   logic              rx_ok_ff;
   logic [31:0]       par_ff [PAR_DEPTH];
   logic [PW:0]       par_idx_ff;
   logic [3:0]        par_hdr_ff;
   logic [31:0]       nxt_rdata;
   logic [31:0]       nxt_lfsr;
   rtp_word0_t        w0_out;
   rtp_word0_t        w0_in;
   fec_sel_t          sel_in;
   logic [15:0]       chk_off;
   logic [6:0]        chk_len;

   // Software side
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         en_ff  <= 1'b0;
         pad_ff <= 1'b0;
         ext_ff <= 1'b0;
         pt_ff  <= RST_PT;
      end else if (reg_wr && reg_addr == OFS_CTRL) begin
         en_ff  <= reg_wdata[CTRL_EN_BIT];
         pad_ff <= reg_wdata[CTRL_PAD_BIT];  // [R15]
         ext_ff <= reg_wdata[CTRL_EXT_BIT];  // [R15]
         pt_ff  <= reg_wdata[CTRL_PT_LSB +: 7]; // [R16]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         win_ff <= '{cols: RST_WIN, rows: RST_WIN};
         cc_ff  <= 4'h0;
      end else if (reg_wr && reg_addr == OFS_WINDOW) begin
         win_ff <= reg_wdata[15:0];
      end else if (reg_wr && reg_addr == OFS_CCOUNT) begin
         cc_ff  <= reg_wdata[3:0];  // [R3]
      end
   end

   // One table per session: only one list, so sources cannot mix sessions
   generate
      for (genvar gi = 0; gi < CSRC_MAX; gi++) begin : g_csrc
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               csrc_ff[gi] <= 32'h0;
            end else if (reg_wr && reg_addr == OFS_CSRC0 + 8'(4 * gi)) begin
               csrc_ff[gi] <= reg_wdata;  // [R3] [R17]
            end
         end
      end
   endgenerate

   // Entropy: reset start is fixed, so software should stir in a seed
   assign nxt_lfsr = {lfsr_ff[30:0],
                      lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lfsr_ff <= RST_LFSR;
      end else if (reg_wr && reg_addr == OFS_SEED) begin
         lfsr_ff <= nxt_lfsr ^ reg_wdata;
      end else begin
         lfsr_ff <= nxt_lfsr;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ssrc_ff <= 32'h0;
      end else if (!seeded_ff) begin
         ssrc_ff <= lfsr_ff;  // [R6]
      end else if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_REROLL_BIT]) begin
         ssrc_ff <= lfsr_ff ^ ssrc_ff;  // [R6]
      end else if (reg_wr && reg_addr == OFS_SSRC) begin
         ssrc_ff <= reg_wdata;  // [R6]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tick_ff <= 32'h0;
      end else begin
         tick_ff <= tick_ff + 32'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         par_rd_idx_ff <= '0;
      end else if (reg_wr && reg_addr == OFS_PARRD) begin
         par_rd_idx_ff <= reg_wdata[PW-1:0];
      end
   end

   always_comb begin
      nxt_rdata = 32'h0;
      unique case (reg_addr)
         OFS_CTRL:   nxt_rdata = {17'h0, pt_ff, 5'h0, ext_ff, pad_ff, en_ff};
         OFS_SSRC:   nxt_rdata = ssrc_ff;
         OFS_WINDOW: nxt_rdata = {16'h0, win_ff};
         OFS_CCOUNT: nxt_rdata = {28'h0, cc_ff};
         OFS_STATUS: nxt_rdata = {refuse_cnt_ff, drop_cnt_ff, seq_ff};
         OFS_TSTAMP: nxt_rdata = tick_ff;
         OFS_PARRD:  nxt_rdata = par_ff[par_rd_idx_ff];  // [R14]
         default: begin
            for (int i = 0; i < CSRC_MAX; i++) begin
               if (reg_addr == OFS_CSRC0 + 8'(4 * i)) begin
                  nxt_rdata = csrc_ff[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_rd ? nxt_rdata : 32'h0;
      end
   end

   // Header builder
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         seeded_ff <= 1'b0;
         seq_ff    <= 16'h0;
      end else if (!seeded_ff) begin
         seeded_ff <= 1'b1;
         seq_ff    <= lfsr_ff[31:16];  // [R4]
      end else if (tx_st_ff == TX_SEL) begin
         seq_ff    <= seq_ff + 16'h1;  // [R4]
      end
   end

   always_comb begin
      w0_out.ver  = RTP_VERSION;  // [R1]
      w0_out.pad  = pad_ff;       // [R15]
      w0_out.ext  = ext_ff;       // [R15]
      w0_out.cc   = cc_ff;        // [R3]
      w0_out.mark = 1'b0;         // [R2]
      w0_out.pt   = pt_ff;        // [R16]
      w0_out.seq  = seq_ff;       // [R4]
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_st_ff   <= TX_IDLE;
         tx_ci_ff   <= 4'h0;
         tx_retx_ff <= 1'b0;
      end else begin
         unique case (tx_st_ff)
            TX_IDLE: begin
               if (tx_start && en_ff && seeded_ff &&
                   (tx_retx || fits_window(tx_shape, win_ff))) begin  // [R9]
                  tx_st_ff   <= TX_W0;
                  tx_retx_ff <= tx_retx;
               end
            end
            TX_W0:   tx_st_ff <= TX_TS;
            TX_TS:   tx_st_ff <= TX_SSRC;
            TX_SSRC: begin
               tx_ci_ff <= 4'h0;
               tx_st_ff <= (cc_ff == 4'h0) ? TX_SEL : TX_CSRC;
            end
            TX_CSRC: begin
               tx_ci_ff <= tx_ci_ff + 4'h1;
               if (tx_ci_ff + 4'h1 == cc_ff) begin
                  tx_st_ff <= TX_SEL;
               end
            end
            TX_SEL:  tx_st_ff <= TX_IDLE;
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_word  <= 32'h0;
         tx_valid <= 1'b0;
         tx_last  <= 1'b0;
      end else begin
         tx_valid <= tx_st_ff != TX_IDLE;
         tx_last  <= tx_st_ff == TX_SEL;
         unique case (tx_st_ff)
            TX_IDLE: tx_word <= 32'h0;
            TX_W0:   tx_word <= w0_out;
            TX_TS:   tx_word <= tick_ff;  // [R5]
            TX_SSRC: tx_word <= ssrc_ff;  // [R6]
            TX_CSRC: tx_word <= csrc_ff[CW'(tx_ci_ff)];  // [R3]
            // Original header and payload of a resend follow this word
            TX_SEL:  tx_word <= {tx_retx_ff, 1'b0, 30'h0};  // [R19] [R12]
            default: tx_word <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_refused    <= 1'b0;
         refuse_cnt_ff <= 8'h0;
      end else begin
         tx_refused <= tx_start && tx_st_ff == TX_IDLE && !tx_retx &&
                       !fits_window(tx_shape, win_ff);  // [R9]
         refuse_cnt_ff <= refuse_cnt_ff + 8'(tx_refused);  // [R9]
      end
   end

   // Header checker
   assign w0_in  = rx_word;
   assign sel_in = rx_word;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_st_ff   <= RX_IDLE;
         rx_ci_ff   <= 4'h0;
         rx_cc_ff   <= 4'h0;
         rx_ok_ff   <= 1'b0;
         rx_accept  <= 1'b0;
         rx_discard <= 1'b0;
         rx_is_retx <= 1'b0;
      end else begin
         rx_accept  <= 1'b0;
         rx_discard <= 1'b0;
         if (rx_valid && rx_first) begin
            // Marker bit deliberately not looked at
            rx_ok_ff <= w0_in.ver == RTP_VERSION && w0_in.pt == pt_ff;  // [R1] [R2] [R16]
            rx_cc_ff <= w0_in.cc;
            rx_st_ff <= RX_TS;
         end else if (rx_valid) begin
            unique case (rx_st_ff)
               RX_IDLE: rx_st_ff <= RX_IDLE;
               RX_TS:   rx_st_ff <= RX_SSRC;
               RX_SSRC: begin
                  rx_ci_ff <= 4'h0;
                  rx_st_ff <= (rx_cc_ff == 4'h0) ? RX_SEL : RX_CSRC;
               end
               RX_CSRC: begin
                  rx_ci_ff <= rx_ci_ff + 4'h1;
                  if (rx_ci_ff + 4'h1 == rx_cc_ff) begin
                     rx_st_ff <= RX_SEL;
                  end
               end
               RX_SEL: begin
                  rx_st_ff <= RX_IDLE;
                  // Both selector bits set is reserved: drop; any shape else passes
                  if (rx_ok_ff && !(sel_in.retx && sel_in.fixed)) begin  // [R10] [R11]
                     rx_accept  <= 1'b1;
                     rx_is_retx <= sel_in.retx;  // [R19]
                  end else begin
                     rx_discard <= 1'b1;  // [R16]
                  end
               end
               default: rx_st_ff <= RX_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         drop_cnt_ff <= 8'h0;
      end else if (rx_discard) begin
         drop_cnt_ff <= drop_cnt_ff + 8'h1;
      end
   end

   // Mask test
   assign chk_off = chk_seq - protected_sequence_origin;  // [R21]
   assign chk_len = !chk_cont[0] ? MASK_LEN_S :
                    (!chk_cont[1] ? MASK_LEN_M : MASK_LEN_L);  // [R20] [R8]

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         chk_hit  <= 1'b0;
         chk_done <= 1'b0;
      end else begin
         chk_done <= chk_valid;
         if (chk_valid) begin
            chk_hit <= (chk_off < {9'h0, chk_len}) &&
                       chk_mask[MASK_TOP - chk_off[6:0]];  // [R8] [R10]
         end
      end
   end

   // Parity store, source words never modified on their way through
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         par_idx_ff <= '0;
         par_hdr_ff <= 4'h0;
         par_busy   <= 1'b0;
      end else begin
         par_busy <= par_valid;
         if (par_valid && par_first) begin
            par_hdr_ff <= 4'h1;
            par_idx_ff <= '0;
         end else if (par_valid && par_hdr_ff != HDR_WORDS) begin
            par_hdr_ff <= par_hdr_ff + 4'h1;  // [R7] [R13]
         end else if (par_valid && par_idx_ff != (PW+1)'(PAR_DEPTH)) begin
            par_idx_ff <= par_idx_ff + (PW+1)'(1);
         end
      end
   end

   generate
      for (genvar gp = 0; gp < PAR_DEPTH; gp++) begin : g_par
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               par_ff[gp] <= 32'h0;
            end else if (reg_wr && reg_addr == OFS_PARRD && reg_wdata[31]) begin
               par_ff[gp] <= 32'h0;
            end else if (par_valid && !par_first && par_hdr_ff == HDR_WORDS &&
                         par_idx_ff == (PW+1)'(gp)) begin
               par_ff[gp] <= par_ff[gp] ^ par_data;  // [R18] [R7] [R14]
            end
         end
      end
   endgenerate

endmodule // fec_repair_hdr
`default_nettype wire

// >>> verification/fec_repair_hdr_assertions.sv
// Port checker for the repair header block
`timescale 1ns/1ps
`default_nettype none
module fec_repair_hdr_chk
   import fec_hdr_pkg::*;
(
   input wire logic           mclk,
   input wire logic           rst_n,
   input wire logic           reg_rd,
   input wire logic [31:0]    reg_rdata,
   input wire logic [31:0]    tx_word,
   input wire logic           tx_valid,
   input wire logic           tx_last,
   input wire logic           tx_refused,
   input wire logic           rx_accept,
   input wire logic           rx_discard,
   input wire logic           rx_is_retx,
   input wire logic           chk_valid,
   input wire logic [15:0]    chk_seq,
   input wire logic [15:0]    protected_sequence_origin,
   input wire logic [109:0]   chk_mask,
   input wire logic [1:0]     chk_cont,
   input wire logic           chk_hit,
   input wire logic           chk_done
);
   logic [15:0] off;
   logic [6:0]  len;
   logic        hit_c;
   // Offset wraps, so an origin near the top still reaches low numbers
   assign off   = chk_seq - protected_sequence_origin;
   assign len   = !chk_cont[0] ? MASK_LEN_S : (!chk_cont[1] ? MASK_LEN_M : MASK_LEN_L);
   assign hit_c = (off < 16'(len)) && chk_mask[MASK_TOP - off[6:0]];

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_mask_answer: assert property (chk_valid |=> chk_done && chk_hit == $past(hit_c))
      else $error("mask answer wrong");
   chk_done_cause: assert property (chk_done |-> $past(chk_valid))
      else $error("mask done without request");
   chk_hdr_version: assert property ($rose(tx_valid) |-> tx_word[31:30] == RTP_VERSION)
      else $error("header version wrong");
   chk_marker_low: assert property ($rose(tx_valid) |-> !tx_word[23])
      else $error("marker bit set");
   chk_selector_tail: assert property (tx_last |-> tx_valid && tx_word[30:0] == 31'h0)
      else $error("selector word wrong");
   chk_stream_run: assert property (tx_valid && !tx_last |=> tx_valid)
      else $error("header stream broken");
   chk_refuse_pulse: assert property (tx_refused |=> !tx_refused && !tx_valid)
      else $error("refusal not a lone pulse");
   chk_rx_verdict: assert property ((rx_accept || rx_discard) |->
      !(rx_accept && rx_discard) ##1 !(rx_accept || rx_discard))
      else $error("receive verdict wrong");
   chk_retx_hold: assert property ($changed(rx_is_retx) |-> rx_accept)
      else $error("retransmit flag moved alone");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data without read");

   cover property ($rose(tx_valid));
   cover property (tx_refused);
   cover property (rx_discard);
   cover property (chk_done && chk_hit);
endmodule // fec_repair_hdr_chk

bind fec_repair_hdr fec_repair_hdr_chk chk_i (
   .mclk, .rst_n, .reg_rd, .reg_rdata, .tx_word, .tx_valid, .tx_last, .tx_refused,
   .rx_accept, .rx_discard, .rx_is_retx, .chk_valid, .chk_seq,
   .protected_sequence_origin, .chk_mask, .chk_cont, .chk_hit, .chk_done
);
`default_nettype wire

// >>> verification/fec_repair_hdr_bench.sv
// Self-checking bench for the repair header block
`timescale 1ns/1ps
`default_nettype none
module fec_repair_hdr_bench;
   import fec_hdr_pkg::*;
   logic         mclk, rst_n, reg_wr, reg_rd, tx_start, tx_retx, tx_valid, tx_last;
   logic         tx_refused, rx_valid, rx_first, rx_accept, rx_discard, rx_is_retx;
   logic         chk_valid, chk_hit, chk_done, par_valid, par_first, par_busy;
   logic         send, slow, refd;
   logic [7:0]   reg_addr;
   logic [31:0]  reg_wdata, reg_rdata, tx_word, rx_word, par_data, w0, sel, d, t;
   logic [15:0]  chk_seq, protected_sequence_origin, seq;
   logic [109:0] chk_mask;
   logic [1:0]   chk_cont;
   win_t         tx_shape;
   logic [31:0]  txw [8];
   int           errors, num_checks, n;
   // Row: write flag, address, write data, read back value
   logic [72:0]  rows [8] = '{
      {1'b0, OFS_CTRL, 32'h0, 32'h0000_6000}, {1'b0, OFS_WINDOW, 32'h0, 32'h0000_0a0a},
      {1'b0, OFS_CCOUNT, 32'h0, 32'h0}, {1'b1, OFS_SSRC, 32'h1234_5678, 32'h1234_5678},
      {1'b1, OFS_CCOUNT, 32'h1, 32'h1}, {1'b1, OFS_CSRC0, 32'hcafe_0001, 32'hcafe_0001},
      {1'b1, 8'h20, 32'hffff_ffff, 32'h0}, {1'b1, OFS_CTRL, 32'h0000_7703, 32'h0000_7703}};

   always #2.5 mclk = ~mclk;

   fec_repair_hdr dut (
      .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .tx_start, .tx_retx, .tx_shape, .tx_word, .tx_valid, .tx_last, .tx_refused,
      .rx_word, .rx_valid, .rx_first, .rx_accept, .rx_discard, .rx_is_retx,
      .chk_valid, .chk_seq, .protected_sequence_origin, .chk_mask, .chk_cont,
      .chk_hit, .chk_done, .par_valid, .par_first, .par_data, .par_busy);
   rtp_peer_model peer (.mclk, .rst_n, .send, .slow, .w0, .sel, .rx_word, .rx_valid,
      .rx_first);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic tx(input logic retx, input logic [15:0] shape);
      @(posedge mclk);
      tx_start <= 1'b1;
      tx_retx  <= retx;
      tx_shape <= shape;
      n = 0;
      refd = 1'b0;
      for (int k = 0; k < 20; k++) begin
         @(posedge mclk);
         tx_start <= 1'b0;
         #1;
         if (tx_refused === 1'b1) refd = 1'b1;
         if (tx_valid === 1'b1) txw[n++] = tx_word;
         if (refd || tx_last === 1'b1) break;
      end
      if (!refd && tx_last !== 1'b1) begin
         errors++;
         final_report();
      end
   endtask

   // Peer sends one header; the verdict must come within a bounded wait
   task automatic rx(input logic [31:0] h, input logic [31:0] s, input logic sl,
                     input logic [1:0] exp);
      logic [1:0] got;
      got = 2'b00;
      @(posedge mclk);
      w0   <= h;
      sel  <= s;
      slow <= sl;
      send <= 1'b1;
      @(posedge mclk);
      send <= 1'b0;
      for (int k = 0; k < 20 && got === 2'b00; k++) begin
         @(posedge mclk);
         #1 got = {rx_accept, rx_discard};
      end
      check(32'(got), 32'(exp));
      if (got === 2'b00) final_report();
   endtask

   task automatic mk(input logic [15:0] s, input logic [15:0] o, input int bpos,
                     input logic [1:0] c, input logic exp);
      @(posedge mclk);
      chk_valid <= 1'b1;
      chk_seq   <= s;
      protected_sequence_origin <= o;
      chk_cont  <= c;
      chk_mask  <= 110'h1 << bpos;
      @(posedge mclk);
      chk_valid <= 1'b0;
      #1 check(32'({chk_done, chk_hit}), 32'({1'b1, exp}));
   endtask

   // Header words get all ones so a parity that skips nothing shows up
   task automatic par(input logic [31:0] a, input logic [31:0] b);
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         par_valid <= 1'b1;
         par_first <= i == 0;
         par_data  <= i == 3 ? a : (i == 4 ? b : 32'hffff_ffff);
      end
      @(posedge mclk);
      par_valid <= 1'b0;
   endtask

   function automatic logic [31:0] hw(input logic [1:0] v, input logic m,
                                      input logic [6:0] pt);
      return {v, 2'b00, 4'h0, m, pt, 16'h0001};
   endfunction

   initial begin
      {mclk, reg_wr, reg_rd, tx_start, tx_retx, chk_valid, par_valid, par_first} = '0;
      {send, slow, rst_n, reg_addr, reg_wdata, par_data, w0, sel} = '0;
      {chk_seq, protected_sequence_origin, chk_mask, chk_cont, tx_shape} = '0;
      {errors, num_checks} = '0;
      repeat (15) @(posedge mclk);
      #1 check(32'({tx_valid, tx_refused, rx_accept, chk_done, par_busy}), 32'h0);
      @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         if (rows[i][72]) wr(rows[i][71:64], rows[i][63:32]);
         rd(rows[i][71:64], d);
         check(d, rows[i][31:0]);
      end
      rd(OFS_STATUS, d);
      seq = d[15:0];
      rd(OFS_TSTAMP, t);
      tx(1'b0, 16'h0a0a);
      check(32'(n), 32'h5);
      check(txw[0], {RTP_VERSION, 1'b1, 1'b0, 4'h1, 1'b0, 7'h77, seq});
      check(32'(txw[1] - t < 32'h20), 32'h1);
      check(txw[2], 32'h1234_5678);
      check(txw[3], 32'hcafe_0001);
      check(txw[4], 32'h0);
      tx(1'b1, 16'hff00);
      check(32'(txw[0][15:0]), 32'(seq + 16'h1));
      check(txw[4], 32'h8000_0000);
      tx(1'b0, 16'h0b01);
      check(32'(refd), 32'h1);
      tx(1'b0, 16'h010b);
      check(32'(refd), 32'h1);
      tx(1'b0, 16'h0000);
      check(32'(refd), 32'h1);
      rx(hw(2'h2, 1'b1, 7'h77), 32'h0, 1'b0, 2'b10);
      check(32'(rx_is_retx), 32'h0);
      rx(hw(2'h2, 1'b0, 7'h77), 32'h8000_0000, 1'b1, 2'b10);
      check(32'(rx_is_retx), 32'h1);
      rx(hw(2'h1, 1'b0, 7'h77), 32'h0, 1'b0, 2'b01);
      rx(hw(2'h2, 1'b0, 7'h60), 32'h0, 1'b0, 2'b01);
      rx(hw(2'h2, 1'b0, 7'h77), 32'hc000_0000, 1'b1, 2'b01);
      check(32'(rx_is_retx), 32'h1);
      rd(OFS_STATUS, d);
      check(32'(d[31:24]), 32'h3);
      check(32'(d[23:16]), 32'h3);
      mk(16'h0003, 16'hfffe, 104, 2'b00, 1'b1);
      mk(16'h0003, 16'hfffe, 105, 2'b00, 1'b0);
      mk(16'h0014, 16'h0000, 89, 2'b00, 1'b0);
      mk(16'h0014, 16'h0000, 89, 2'b01, 1'b1);
      mk(16'h006d, 16'h0000, 0, 2'b01, 1'b0);
      mk(16'h006d, 16'h0000, 0, 2'b11, 1'b1);
      wr(OFS_PARRD, 32'h8000_0000);
      par(32'h1111_0f0f, 32'h00ff_00ff);
      par(32'h2222_ffff, 32'hff00_0000);
      wr(OFS_PARRD, 32'h0);
      rd(OFS_PARRD, d);
      check(d, 32'h3333_f0f0);
      wr(OFS_PARRD, 32'h1);
      rd(OFS_PARRD, d);
      check(d, 32'hffff_00ff);
      wr(OFS_CTRL, 32'h0000_770b);
      rd(OFS_SSRC, d);
      check(32'(d != 32'h1234_5678), 32'h1);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rd(OFS_CTRL, d);
      check(d, 32'h0000_6000);
      final_report();
   end
endmodule // fec_repair_hdr_bench
`default_nettype wire

// >>> verification/rtp_peer_model.sv
// Remote endpoint that sends one four-word repair header on request
`timescale 1ns/1ps
`default_nettype none
module rtp_peer_model (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        send,
   input  wire logic        slow,
   input  wire logic [31:0] w0,
   input  wire logic [31:0] sel,
   output logic [31:0]      rx_word,
   output logic             rx_valid,
   output logic             rx_first
);
   logic [2:0]  step_ff;
   logic        gap_ff;
   logic [31:0] words [4];
   assign words = '{w0, 32'h0000_1000, 32'h5500_aa00, sel};

   always_ff @(posedge mclk) begin
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      // Idle line toggles so a stale word is never taken for data
      rx_word  <= ~rx_word;
      if (!rst_n) begin
         step_ff <= 3'h0;
         gap_ff  <= 1'b0;
         rx_word <= 32'h0;
      end else if (step_ff == 3'h0) begin
         if (send) step_ff <= 3'h1;
      end else begin
         gap_ff <= slow && !gap_ff;
         if (!gap_ff) begin
            rx_valid <= 1'b1;
            rx_first <= step_ff == 3'h1;
            rx_word  <= words[step_ff - 3'h1];
            step_ff  <= step_ff == 3'h4 ? 3'h0 : step_ff + 3'h1;
         end
      end
   end
endmodule // rtp_peer_model
`default_nettype wire
